// ===== rtl/tpf_map.svh
// Register offsets, field positions, reset values and timing counts of the fan commutation block
// Functional notes
// R1: Phase two is the active output while the Hall comparison says H+ is above H-, phase one otherwise.
// R2: The speed command spans from the zero-drive end to the full-drive end, with duty varying linearly between.
// R3: A speed command beyond the zero-drive end holds PWM drive fully off and so acts as a drive disable.
// R4: The internal speed command is clamped so it never passes the minimum-speed setting toward low speed.
// R5: The phase PWM runs at a configurable period, near 24kHz for the reference setting.
// R6: A rotor stopped for the lock-detect interval raises the lock status and turns both phases off.
// R7: While locked, an off interval and a drive-enabled retry interval alternate until rotation resumes.
// R8: The retry interval and the off interval stand in a one-to-twelve ratio.
// R9: The lock status line is actively pulled low while running and released high while stopped.
// R10: The tachometer line copies the Hall polarity, pulled low actively and released for high.
// R11: The inactive phase output is held low for as long as it is not selected.
// R12: The active phase carries the PWM, driven high in the on part and actively low in the off part.
// R13: A fixed-speed system holds the speed command constant, or at the ground end for full drive.
// R14: Every Hall transition restarts the lock-detect timer; lock is declared only after a full timeout.
// The code's ticks run free, so lock can come a tick early, and off-interval Hall edges are ignored.
// R15: A Hall transition during a retry interval leaves the locked state and resumes normal commutation.
`ifndef TPF_MAP_SVH
`define TPF_MAP_SVH

// Timing
`define TPF_SYS_CLK_HZ 100000000
`define TPF_PWM_FREQ_HZ 24000
`define TPF_SPEED_SPAN 8'hc8
`define TPF_PWM_DIV_RESET ((`TPF_SYS_CLK_HZ + (`TPF_PWM_FREQ_HZ * `TPF_SPEED_SPAN) / 2) / (`TPF_PWM_FREQ_HZ * `TPF_SPEED_SPAN))
`define TPF_LOCK_TICK_MS 1
`define TPF_LOCK_TICK_CYCLES (`TPF_SYS_CLK_HZ / 1000 * `TPF_LOCK_TICK_MS)
`define TPF_RETRY_OFF_RATIO 20'h0000c

// Register byte offsets
`define TPF_ADDR_CTRL 8'h00
`define TPF_ADDR_SPEED 8'h04
`define TPF_ADDR_MIN_SPEED 8'h08
`define TPF_ADDR_PWM_PERIOD 8'h0c
`define TPF_ADDR_LOCK_TIME 8'h10
`define TPF_ADDR_STATUS 8'h14
`define TPF_ADDR_INT_STATUS 8'h18
`define TPF_ADDR_INT_MASK 8'h1c

// Reset values
`define TPF_CTRL_RESET 1'b1
`define TPF_SPEED_RESET 8'h00
`define TPF_MIN_SPEED_RESET 8'hc8
`define TPF_LOCK_TIME_RESET 16'h01f4
`define TPF_INT_MASK_RESET 3'h0

// Interrupt status bit positions
`define TPF_INT_LOCK_ENTER 0
`define TPF_INT_LOCK_EXIT 1
`define TPF_INT_HALL_EDGE 2

`endif

// ===== rtl/tpf_pkg.sv
// Types shared by the fan commutation block
package tpf_pkg;
  typedef enum logic [1:0] {LK_RUN, LK_OFF, LK_RETRY} tpf_lock_state_type;
  typedef logic [7:0] tpf_code_type;
endpackage

// ===== rtl/tpf_reg_if.sv
// Register access carrier between bus slave and register file
`timescale 1ns/10ps
interface tpf_reg_if;
  logic wrEn;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [7:0] rdAddr;
  logic [31:0] rdData;
  modport bus (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport regs (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// ===== rtl/tpf_ahb_slave.sv
// AHB-Lite slave front end for the fan commutation registers
`timescale 1ns/10ps
module tpf_ahb_slave (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Register side
  tpf_reg_if.bus regBus
);
  logic wrPend;
  logic [7:0] wrAddrQ;
  wire accept;
  wire wordOk;

  // Address phase decode
  assign accept = hsel & htrans[1] & hready;
  assign wordOk = (hsize == 3'h2) & (haddr[1:0] == 2'h0) & (haddr[31:5] == 27'h0);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wrPend <= 1'b0;
      wrAddrQ <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wrPend <= accept & hwrite & wordOk;
      if (accept) begin
        wrAddrQ <= haddr[7:0];
      end
      if (accept & ~hwrite) begin
        hrdata <= wordOk ? regBus.rdData : 32'h0;
      end
    end
  end

  // Write in data phase, read sampled in address phase
  assign regBus.wrEn = wrPend;
  assign regBus.wrAddr = wrAddrQ;
  assign regBus.wrData = hwdata;
  assign regBus.rdAddr = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule

// ===== rtl/tpf_pwm_gen.sv
// PWM period and duty generator for the phase outputs
`timescale 1ns/10ps
`include "tpf_map.svh"
module tpf_pwm_gen import tpf_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Setting
  input wire logic [7:0] periodDiv,
  input tpf_code_type threshold,
  // Result
  output logic pwmOn
);
  logic [7:0] prescale;
  tpf_code_type step;
  wire [7:0] divLimit;
  wire stepTick;
  wire lastStep;

  // Period is span steps of periodDiv cycles each
  assign divLimit = (periodDiv == 8'h00) ? 8'h00 : periodDiv - 8'h01;
  assign stepTick = prescale >= divLimit;
  assign lastStep = step == `TPF_SPEED_SPAN - 8'h01;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prescale <= 8'h00;
      step <= 8'h00;
      pwmOn <= 1'b0;
    end else begin
      prescale <= stepTick ? 8'h00 : prescale + 8'h01; // see R5
      if (stepTick) begin
        step <= lastStep ? 8'h00 : step + 8'h01;
      end
      pwmOn <= step >= threshold; // see R2
    end
  end

  AST_PWM_WRAP: assert property (@(posedge sys_clk) disable iff (!rstn) // see R5
    (stepTick && lastStep) |=> (step == 8'h00))
    else $error("PWM step counter did not wrap at the end of the period");
endmodule

// ===== rtl/tpf_fan_ctrl.sv
// Top of the two-phase fan commutation, PWM and locked-rotor controller
`timescale 1ns/10ps
`include "tpf_map.svh"
module tpf_fan_ctrl import tpf_pkg::*; #(
  parameter int LOCK_TICK_CYCLES = `TPF_LOCK_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Hall comparator, high while H+ is above H-
  input wire logic hallCompare,
  // Phase drives
  output logic phaseOneDrive,
  output logic phaseTwoDrive,
  // Open-drain tachometer
  output logic tachoOut,
  output logic tachoOeN,
  // Open-drain lock status
  output logic lockOut,
  output logic lockOeN,
  // Interrupt
  output logic irq
);
  tpf_reg_if regBus ();

  // Software registers
  logic ctrlEnable;
  tpf_code_type speedCmdIn;
  tpf_code_type minSpeedSetting;
  logic [7:0] pwmPeriodSetting;
  logic [15:0] lockTimingSetting;
  logic [2:0] intStatus;
  logic [2:0] intMask;

  // Hall synchroniser and edge
  logic hallMeta;
  logic hallSync;
  logic hallPrev;
  wire hallEdge;

  // Lock supervisor
  tpf_lock_state_type lockState;
  tpf_lock_state_type next_state;
  logic [19:0] lockCount;
  logic [19:0] next_lockCount;
  logic [23:0] tickCount;
  wire lockTick;
  wire [19:0] lockLimit;
  wire [19:0] offLimit;

  // Speed path
  wire speedDisable;
  tpf_code_type clampedCmd;
  tpf_code_type effCmd;
  wire pwmOn;
  wire driveRequest;
  wire driveAllowed;
  wire next_phaseOne;
  wire next_phaseTwo;

  // Register decode
  wire wrCtrl;
  wire wrSpeed;
  wire wrMinSpeed;
  wire wrPwmPeriod;
  wire wrLockTime;
  wire wrIntStatus;
  wire wrIntMask;
  wire [2:0] intClear;
  wire [2:0] intEvent;
  wire [2:0] next_intStatus;
  wire [31:0] statusWord;
  wire lockEnterEvt;
  wire lockExitEvt;

  tpf_ahb_slave u_bus (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .regBus(regBus.bus)
  );

  tpf_pwm_gen u_pwm (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .periodDiv(pwmPeriodSetting),
    .threshold(effCmd),
    .pwmOn(pwmOn)
  );

  // Write strobes
  assign wrCtrl = regBus.wrEn & (regBus.wrAddr == `TPF_ADDR_CTRL);
  assign wrSpeed = regBus.wrEn & (regBus.wrAddr == `TPF_ADDR_SPEED);
  assign wrMinSpeed = regBus.wrEn & (regBus.wrAddr == `TPF_ADDR_MIN_SPEED);
  assign wrPwmPeriod = regBus.wrEn & (regBus.wrAddr == `TPF_ADDR_PWM_PERIOD);
  assign wrLockTime = regBus.wrEn & (regBus.wrAddr == `TPF_ADDR_LOCK_TIME);
  assign wrIntStatus = regBus.wrEn & (regBus.wrAddr == `TPF_ADDR_INT_STATUS);
  assign wrIntMask = regBus.wrEn & (regBus.wrAddr == `TPF_ADDR_INT_MASK);

  // Status word
  assign statusWord = {16'h0, effCmd, 3'h0, speedDisable, phaseTwoDrive,
                       lockState == LK_RETRY, lockState != LK_RUN, hallSync};

  // Read mux, unmapped offsets read zero
  assign regBus.rdData =
    (regBus.rdAddr == `TPF_ADDR_CTRL) ? {31'h0, ctrlEnable} :
    (regBus.rdAddr == `TPF_ADDR_SPEED) ? {24'h0, speedCmdIn} :
    (regBus.rdAddr == `TPF_ADDR_MIN_SPEED) ? {24'h0, minSpeedSetting} :
    (regBus.rdAddr == `TPF_ADDR_PWM_PERIOD) ? {24'h0, pwmPeriodSetting} :
    (regBus.rdAddr == `TPF_ADDR_LOCK_TIME) ? {16'h0, lockTimingSetting} :
    (regBus.rdAddr == `TPF_ADDR_STATUS) ? statusWord :
    (regBus.rdAddr == `TPF_ADDR_INT_STATUS) ? {29'h0, intStatus} :
    (regBus.rdAddr == `TPF_ADDR_INT_MASK) ? {29'h0, intMask} : 32'h0;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrlEnable <= `TPF_CTRL_RESET;
      speedCmdIn <= `TPF_SPEED_RESET;
      minSpeedSetting <= `TPF_MIN_SPEED_RESET;
      pwmPeriodSetting <= 8'(`TPF_PWM_DIV_RESET);
      lockTimingSetting <= `TPF_LOCK_TIME_RESET;
      intMask <= `TPF_INT_MASK_RESET;
    end else begin
      if (wrCtrl) ctrlEnable <= regBus.wrData[0];
      if (wrSpeed) speedCmdIn <= regBus.wrData[7:0];
      if (wrMinSpeed) minSpeedSetting <= regBus.wrData[7:0];
      if (wrPwmPeriod) pwmPeriodSetting <= regBus.wrData[7:0];
      if (wrLockTime) lockTimingSetting <= regBus.wrData[15:0];
      if (wrIntMask) intMask <= regBus.wrData[2:0];
    end
  end

  // Hall input synchroniser
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hallMeta <= 1'b0;
      hallSync <= 1'b0;
      hallPrev <= 1'b0;
    end else begin
      hallMeta <= hallCompare;
      hallSync <= hallMeta;
      hallPrev <= hallSync;
    end
  end

  assign hallEdge = hallSync ^ hallPrev;

  // Speed command clamp and disable
  assign speedDisable = speedCmdIn > `TPF_SPEED_SPAN; // see R3
  assign clampedCmd = (speedCmdIn > minSpeedSetting) ? minSpeedSetting : speedCmdIn; // see R4
  assign effCmd = speedDisable ? `TPF_SPEED_SPAN : clampedCmd; // see R2

  // Drive gating
  assign driveRequest = ctrlEnable & ~speedDisable; // see R3
  assign driveAllowed = driveRequest & (lockState != LK_OFF); // see R6
  assign next_phaseTwo = driveAllowed & hallSync & pwmOn; // see R1
  assign next_phaseOne = driveAllowed & ~hallSync & pwmOn; // see R11

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phaseOneDrive <= 1'b0;
      phaseTwoDrive <= 1'b0;
    end else begin
      phaseOneDrive <= next_phaseOne; // see R12
      phaseTwoDrive <= next_phaseTwo; // see R12
    end
  end

  // Lock timebase
  assign lockTick = tickCount >= 24'(LOCK_TICK_CYCLES - 1);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tickCount <= 24'h0;
    end else begin
      tickCount <= lockTick ? 24'h0 : tickCount + 24'h1;
    end
  end

  assign lockLimit = (lockTimingSetting == 16'h0) ? 20'h1 : {4'h0, lockTimingSetting};
  assign offLimit = 20'(lockLimit * `TPF_RETRY_OFF_RATIO); // see R8

  // Lock supervisor
  always_comb begin
    next_state = lockState;
    next_lockCount = lockCount;
    unique case (lockState)
      LK_RUN: begin
        if (hallEdge || !driveRequest) begin
          next_lockCount = 20'h0; // see R14
        end else if (lockTick) begin
          if (lockCount >= lockLimit - 20'h1) begin
            next_state = LK_OFF; // see R6
            next_lockCount = 20'h0;
          end else begin
            next_lockCount = lockCount + 20'h1;
          end
        end
      end
      LK_OFF: begin
        if (lockTick) begin
          if (lockCount >= offLimit - 20'h1) begin
            next_state = LK_RETRY; // see R7
            next_lockCount = 20'h0;
          end else begin
            next_lockCount = lockCount + 20'h1;
          end
        end
      end
      LK_RETRY: begin
        if (hallEdge) begin
          next_state = LK_RUN; // see R15
          next_lockCount = 20'h0;
        end else if (lockTick) begin
          if (lockCount >= lockLimit - 20'h1) begin
            next_state = LK_OFF; // see R7
            next_lockCount = 20'h0;
          end else begin
            next_lockCount = lockCount + 20'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lockState <= LK_RUN;
      lockCount <= 20'h0;
      lockOeN <= 1'b0;
      tachoOeN <= 1'b0;
    end else begin
      lockState <= next_state;
      lockCount <= next_lockCount;
      lockOeN <= next_state != LK_RUN; // see R9
      tachoOeN <= hallSync; // see R10
    end
  end

  // Open-drain lines only ever drive low
  assign tachoOut = 1'b0;
  assign lockOut = 1'b0;

  // Interrupt status, set wins over write-one-to-clear
  assign lockEnterEvt = (lockState == LK_RUN) && (next_state == LK_OFF);
  assign lockExitEvt = (lockState == LK_RETRY) && (next_state == LK_RUN);
  assign intEvent = {hallEdge, lockExitEvt, lockEnterEvt};
  assign intClear = wrIntStatus ? regBus.wrData[2:0] : 3'h0;
  assign next_intStatus = (intStatus & ~intClear) | intEvent;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      intStatus <= 3'h0;
    end else begin
      intStatus <= next_intStatus;
    end
  end

  assign irq = |(intStatus & intMask);

  // Checks
  AST_PHASE_TWO_SEL: assert property (@(posedge sys_clk) disable iff (!rstn) // see R1
    phaseTwoDrive |-> $past(hallSync))
    else $error("Phase two driven while Hall polarity selected phase one");

  AST_INACTIVE_LOW: assert property (@(posedge sys_clk) disable iff (!rstn) // see R11
    $past(hallSync) |-> !phaseOneDrive)
    else $error("Phase one not held low while phase two selected");

  AST_NO_OVERLAP: assert property (@(posedge sys_clk) disable iff (!rstn) // see R11
    !(phaseOneDrive && phaseTwoDrive))
    else $error("Both phases driven together");

  AST_PWM_GATE: assert property (@(posedge sys_clk) disable iff (!rstn) // see R12
    (phaseOneDrive || phaseTwoDrive) |-> $past(pwmOn))
    else $error("Phase driven during the off part of the PWM period");

  AST_FULL_DUTY: assert property (@(posedge sys_clk) disable iff (!rstn) // see R2
    ($past(effCmd) == 8'h00 && $past(rstn)) |-> pwmOn)
    else $error("Zero speed code did not give full PWM duty");

  AST_DISABLE_OFF: assert property (@(posedge sys_clk) disable iff (!rstn) // see R3
    ($past(speedCmdIn) > `TPF_SPEED_SPAN) |-> (!phaseOneDrive && !phaseTwoDrive))
    else $error("Drive not off with speed command beyond zero-drive end");

  AST_MIN_CLAMP: assert property (@(posedge sys_clk) disable iff (!rstn) // see R4
    !speedDisable |-> (effCmd <= minSpeedSetting && effCmd <= speedCmdIn))
    else $error("Effective speed command passed the minimum speed setting");

  AST_LOCK_ENTER: assert property (@(posedge sys_clk) disable iff (!rstn) // see R6
    lockEnterEvt |=> (lockOeN ##1 (!phaseOneDrive && !phaseTwoDrive)))
    else $error("Lock entry did not raise status and stop both phases");

  AST_LOCK_PIN: assert property (@(posedge sys_clk) disable iff (!rstn) // see R9
    lockOeN == (lockState != LK_RUN))
    else $error("Lock status line does not follow the lock state");

  AST_OFF_RATIO: assert property (@(posedge sys_clk) disable iff (!rstn) // see R8
    (lockState == LK_OFF && next_state == LK_RETRY) |-> (lockCount == offLimit - 20'h1)
      && (offLimit == 20'(lockLimit * `TPF_RETRY_OFF_RATIO)))
    else $error("Off interval not twelve times the retry interval");

  AST_RETRY_LOOP: assert property (@(posedge sys_clk) disable iff (!rstn) // see R7
    (lockState == LK_RETRY && !hallEdge && lockTick && lockCount >= lockLimit - 20'h1)
      |=> (lockState == LK_OFF && lockCount == 20'h0))
    else $error("Retry interval did not return to the off interval");

  AST_LOCK_RESTART: assert property (@(posedge sys_clk) disable iff (!rstn) // see R14
    (lockState == LK_RUN && hallEdge) |=> (lockState == LK_RUN && lockCount == 20'h0))
    else $error("Hall edge did not restart the lock timer");

  AST_RETRY_EXIT: assert property (@(posedge sys_clk) disable iff (!rstn) // see R15
    (lockState == LK_RETRY && hallEdge) |=> (lockState == LK_RUN && !lockOeN))
    else $error("Hall edge in retry did not resume normal running");

  AST_TACHO_FOLLOW: assert property (@(posedge sys_clk) disable iff (!rstn) // see R10
    hallEdge |=> (tachoOeN != $past(tachoOeN)))
    else $error("Tachometer line did not follow a Hall transition");

  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!rstn)
    (lockEnterEvt && intClear[`TPF_INT_LOCK_ENTER]) |=> intStatus[`TPF_INT_LOCK_ENTER])
    else $error("Lock event lost against a simultaneous clear");
endmodule

// ===== tb/tpf_fan_model.sv
// Fan rotor, Hall sensor and pull-up model facing the fan controller
`timescale 1ns/10ps
module tpf_fan_model #(
  parameter int HALF_TURN = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Bench control
  input wire logic stall,
  input wire logic nudge,
  // Controller pins
  input wire logic tachoOut,
  input wire logic tachoOeN,
  input wire logic lockOut,
  input wire logic lockOeN,
  // Sensor and lines
  output logic hallCompare,
  output logic tachoLine,
  output logic lockLine
);
  int turnCount;
  // Free rotor flips the magnet field each half turn, a nudge flips it once
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      turnCount <= 0;
      hallCompare <= 1'b0;
    end else if (nudge || (!stall && turnCount == HALF_TURN - 1)) begin
      turnCount <= 0;
      hallCompare <= !hallCompare;
    end else if (!stall) begin
      turnCount <= turnCount + 1;
    end
  end
  // External pull-ups on the open-drain lines
  assign tachoLine = tachoOeN ? 1'b1 : tachoOut;
  assign lockLine = lockOeN ? 1'b1 : lockOut;
endmodule

// ===== tb/testbench.sv
// Self-checking bench of the fan commutation, PWM and locked-rotor controller
`timescale 1ns/10ps
`include "tpf_map.svh"
module testbench;
  localparam int TICK = 10;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, hallCompare, phaseOneDrive, phaseTwoDrive;
  logic tachoOut, tachoOeN, lockOut, lockOeN, tachoLine, lockLine;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic stall = 1'b1;
  logic nudge = 1'b0;
  int n_errors = 0;
  int compares = 0;
  int lockBad = 0;
  logic [7:0] regAddr [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20};
  logic [31:0] regReset [8] = '{32'h1, 32'h0, 32'hc8, `TPF_PWM_DIV_RESET, 32'h1f4, 32'h0, 32'h0, 32'h0};
  int speed_cmd_in [8] = '{0, 100, 199, 200, 201, 150, 255, 30};
  int mins [8] = '{200, 200, 200, 200, 200, 50, 50, 200};

  always #5 sys_clk = ~sys_clk;

  tpf_fan_ctrl #(.LOCK_TICK_CYCLES(TICK)) i_tpf_fan_ctrl (
    .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .hallCompare(hallCompare), .phaseOneDrive(phaseOneDrive),
    .phaseTwoDrive(phaseTwoDrive), .tachoOut(tachoOut), .tachoOeN(tachoOeN), .lockOut(lockOut),
    .lockOeN(lockOeN), .irq(irq));

  tpf_fan_model i_tpf_fan_model (
    .sys_clk(sys_clk), .rstn(rstn), .stall(stall), .nudge(nudge), .tachoOut(tachoOut),
    .tachoOeN(tachoOeN), .lockOut(lockOut), .lockOeN(lockOeN), .hallCompare(hallCompare),
    .tachoLine(tachoLine), .lockLine(lockLine));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
      if (i > 50) begin
        check(32'h0, 32'h1);
        give_verdict();
      end
    end while (hreadyout !== 1'b1);
  endtask

  task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, addr};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    wait_ready();
    rd = hrdata;
    check(32'(hresp), 32'h0);
  endtask

  task automatic wr(input logic [7:0] addr, input int data);
    ahb(1'b1, addr, 32'(data));
  endtask

  task automatic rdr(input logic [7:0] addr);
    ahb(1'b0, addr, 32'h0);
  endtask

  task automatic do_nudge();
    nudge <= 1'b1;
    @(posedge sys_clk);
    nudge <= 1'b0;
    @(posedge sys_clk);
  endtask

  function automatic int exp_high(input int en, input int s, input int m, input int pv);
    int eff;
    eff = (s < m) ? s : m;
    return (en == 0 || s > 200) ? 0 : 2 * pv * (200 - eff);
  endfunction

  task automatic duty_case(input int en, input int s, input int m, input int pv);
    int n1;
    int n2;
    int e;
    wr(`TPF_ADDR_CTRL, en);
    wr(`TPF_ADDR_PWM_PERIOD, pv);
    wr(`TPF_ADDR_MIN_SPEED, m);
    wr(`TPF_ADDR_SPEED, s);
    do_nudge();
    repeat (200 * pv + 10) @(posedge sys_clk);
    n1 = 0;
    n2 = 0;
    for (int i = 0; i < 400 * pv; i++) begin
      @(posedge sys_clk);
      n1 += (phaseOneDrive === 1'b1);
      n2 += (phaseTwoDrive === 1'b1);
    end
    e = exp_high(en, s, m, pv);
    check(32'(n2), (hallCompare === 1'b1) ? 32'(e) : 32'h0);
    check(32'(n1), (hallCompare === 1'b1) ? 32'h0 : 32'(e));
    check(32'(tachoLine), 32'(hallCompare));
    rdr(`TPF_ADDR_STATUS);
    check(32'(rd[4]), 32'(s > 200));
    if (s <= 200) begin
      check(32'(rd[15:8]), 32'((s < m) ? s : m));
    end
    $display("Duty test en %0d speed %0d min %0d period %0d done", en, s, m, pv);
  endtask

  task automatic wait_level(input logic level, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      lockBad += (lockLine !== 1'b1);
      if (n > 400) begin
        check(32'h0, 32'h1);
        give_verdict();
      end
    end while (((phaseOneDrive | phaseTwoDrive) === level) == 1'b0);
  endtask

  task automatic lock_test();
    int n;
    int bad;
    stall <= 1'b0;
    wr(`TPF_ADDR_CTRL, 1);
    wr(`TPF_ADDR_SPEED, 0);
    wr(`TPF_ADDR_MIN_SPEED, 200);
    wr(`TPF_ADDR_PWM_PERIOD, 1);
    wr(`TPF_ADDR_LOCK_TIME, 2);
    wr(`TPF_ADDR_INT_STATUS, 7);
    wr(`TPF_ADDR_INT_MASK, 1);
    bad = 0;
    repeat (200) begin
      @(posedge sys_clk);
      bad += (lockLine !== 1'b0);
    end
    check(32'(bad), 32'h0);
    stall <= 1'b1;
    do_nudge();
    n = 0;
    while (lockLine !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    check(32'(n >= 8 && n <= 24), 32'h1);
    check(32'(irq), 32'h1);
    @(posedge sys_clk);
    check(32'(phaseOneDrive | phaseTwoDrive), 32'h0);
    wait_level(1'b1, n);
    lockBad = 0;
    for (int k = 0; k < 2; k++) begin
      wait_level(1'b0, n);
      check(32'(n >= 19 && n <= 21), 32'h1);
      wait_level(1'b1, n);
      check(32'(n >= 239 && n <= 241), 32'h1);
    end
    check(32'(lockBad), 32'h0);
    do_nudge();
    n = 0;
    while (lockLine !== 1'b0 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    check(32'(n <= 8), 32'h1);
    wr(`TPF_ADDR_LOCK_TIME, 16'hffff);
    repeat (300) @(posedge sys_clk);
    check(32'(phaseOneDrive | phaseTwoDrive), 32'h1);
    rdr(`TPF_ADDR_INT_STATUS);
    check(rd, 32'h7);
    check(32'(irq), 32'h1);
    wr(`TPF_ADDR_INT_MASK, 0);
    @(posedge sys_clk);
    check(32'(irq), 32'h0);
    wr(`TPF_ADDR_INT_MASK, 2);
    @(posedge sys_clk);
    check(32'(irq), 32'h1);
    wr(`TPF_ADDR_INT_STATUS, 7);
    rdr(`TPF_ADDR_INT_STATUS);
    check(rd, 32'h0);
    check(32'(irq), 32'h0);
    $display("Lock test done");
  endtask

  initial begin
    void'($urandom(32'h0049));
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (int k = 0; k < 8; k++) begin
      rdr(regAddr[k]);
      check(rd, regReset[k]);
    end
    $display("Reset value test done");
    wr(`TPF_ADDR_LOCK_TIME, 16'hffff);
    for (int k = 0; k < 8; k++) begin
      duty_case(1, speed_cmd_in[k], mins[k], (k == 2) ? 2 : 1);
    end
    duty_case(0, 0, 200, 1);
    for (int k = 0; k < 4; k++) begin
      duty_case(1, $urandom_range(0, 255), $urandom_range(0, 200), $urandom_range(1, 2));
    end
    lock_test();
    give_verdict();
  end
endmodule
